//--- common/scmc_consts.svh
`ifndef SCMC_CONSTS_SVH
`define SCMC_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// bus geometry
`define SCMC_ADDR_W 4
`define SCMC_DATA_W 8

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define SCMC_OFS_SYSTEM_CLOCK_CONTROL 4'h0
`define SCMC_OFS_HI_RC_OSC_CONTROL 4'h1
`define SCMC_OFS_HS_CRYSTAL_CONTROL 4'h2
`define SCMC_OFS_LS_CRYSTAL_CONTROL 4'h3

////////////////////////////////////////////////////////////////////////////////
// reset values
`define SCMC_RST_SYSTEM_CLOCK_CONTROL 8'h00
`define SCMC_RST_HI_RC_OSC_CONTROL 8'h01
`define SCMC_RST_HS_CRYSTAL_CONTROL 8'h00
`define SCMC_RST_LS_CRYSTAL_CONTROL 8'h00

////////////////////////////////////////////////////////////////////////////////
// system clock control fields
`define SCMC_SEL_MSB 7
`define SCMC_SEL_LSB 5
`define SCMC_HIGH_SRC_BIT 3
`define SCMC_LOW_SRC_BIT 2
`define SCMC_IDLE_HIGH_BIT 1
`define SCMC_IDLE_LOW_BIT 0

// oscillator control fields
`define SCMC_RC_FREQ_MSB 3
`define SCMC_RC_FREQ_LSB 2
`define SCMC_MODE_BIT 2
`define SCMC_FLAG_BIT 1
`define SCMC_EN_BIT 0

////////////////////////////////////////////////////////////////////////////////
// encodings
`define SCMC_SEL_W 3
`define SCMC_SEL_LOW 3'h7
`define SCMC_DIV_STAGES 6
`define SCMC_RC_FREQ_8MHZ 2'h0
`define SCMC_RC_FREQ_12MHZ 2'h1
`define SCMC_RC_FREQ_16MHZ 2'h2
`define SCMC_SRC_CRYSTAL 1'h1
`define SCMC_SRC_RC 1'h0

`endif

//--- common/scmc_pkg.sv
`include "scmc_consts.svh"

package scmc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // operating modes, one-hot
  typedef enum logic [5:0] {
    SCMC_FAST = 6'h01,
    SCMC_SLOW = 6'h02,
    SCMC_SLEEP = 6'h04,
    SCMC_IDLE_LOW_ONLY = 6'h08,
    SCMC_IDLE_BOTH_CLOCKS = 6'h10,
    SCMC_IDLE_HIGH_ONLY = 6'h20
  } scmc_mode_t;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [`SCMC_ADDR_W-1:0] addr;
    logic [`SCMC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } scmc_bus_req_t;

  typedef struct packed {
    logic hs_crystal_osc;
    logic hs_rc_osc;
    logic ls_crystal_osc;
    logic ls_rc_osc;
  } scmc_osc_t;

  typedef struct packed {
    logic rc_stable_flag;
    logic hs_crystal_stable_flag;
    logic ls_crystal_stable_flag;
  } scmc_stable_t;

  typedef struct packed {
    logic hs_crystal_en;
    logic hs_rc_en;
    logic ls_crystal_en;
    logic ls_rc_en;
    logic [1:0] rc_freq_select;
    logic hs_crystal_range;
    logic ls_crystal_speedup;
  } scmc_osc_ctl_t;

  typedef struct packed {
    logic sysclk;
    logic high_clock;
    logic low_clock;
    logic ls_rc_clock;
    logic cpu_run;
  } scmc_clk_out_t;

  ////////////////////////////////////////////////////////////////////////////////
  // module state
  typedef struct packed {
    logic hi_prev;
    logic [`SCMC_DIV_STAGES-1:0] cnt;
    logic [`SCMC_DIV_STAGES:0] taps;
  } scmc_div_st_t;

  typedef struct packed {
    scmc_mode_t mode;
    logic [`SCMC_SEL_W-1:0] held_sel;
  } scmc_fsm_st_t;

  ////////////////////////////////////////////////////////////////////////////////
  // a selector may only move while both the old and the new clock are low
  function automatic logic scmc_may_switch(input logic old_lvl, input logic new_lvl);
    scmc_may_switch = ~old_lvl & ~new_lvl;
  endfunction : scmc_may_switch

endpackage : scmc_pkg

//--- verilog/scmc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "scmc_consts.svh"

module scmc_clk_div
  import scmc_pkg::*;
#(
  parameter int STAGES = `SCMC_DIV_STAGES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic high_in,
  output logic [STAGES:0] taps
);

  scmc_div_st_t st_q;
  scmc_div_st_t st_d;
  logic rise;

  ////////////////////////////////////////////////////////////////////////////////
  // ripple of high clock rising edges; tap k is the high clock over 2**k
  always_comb begin
    st_d = st_q;
    rise = high_in & ~st_q.hi_prev;
    st_d.hi_prev = high_in;
    st_d.cnt = st_q.cnt + {{(STAGES-1){1'b0}}, rise};
    st_d.taps = {st_d.cnt, high_in};
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign taps = st_q.taps;

endmodule : scmc_clk_div

`default_nettype wire

//--- verilog/scmc_mode_fsm.sv
`timescale 1ns/1ps
`default_nettype none
`include "scmc_consts.svh"

module scmc_mode_fsm
  import scmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic halt,
  input wire logic wake,
  input wire logic idle_high_clock_keep,
  input wire logic idle_low_clock_keep,
  input wire logic [`SCMC_SEL_W-1:0] sysclk_select,
  output scmc_mode_t mode,
  output logic [`SCMC_SEL_W-1:0] held_sel
);

  scmc_fsm_st_t st_q;
  scmc_fsm_st_t st_d;
  logic run_slow;

  ////////////////////////////////////////////////////////////////////////////////
  // run modes follow the select field; halt latches the idle bits and field
  always_comb begin
    st_d = st_q;
    run_slow = (sysclk_select == `SCMC_SEL_LOW);
    case (st_q.mode)
      SCMC_FAST, SCMC_SLOW: begin
        st_d.mode = run_slow ? SCMC_SLOW : SCMC_FAST;
        st_d.held_sel = sysclk_select;
        if (halt) begin
          st_d.held_sel = sysclk_select;
          case ({idle_high_clock_keep, idle_low_clock_keep})
            2'h0: st_d.mode = SCMC_SLEEP;
            2'h1: st_d.mode = SCMC_IDLE_LOW_ONLY;
            2'h3: st_d.mode = SCMC_IDLE_BOTH_CLOCKS;
            default: st_d.mode = SCMC_IDLE_HIGH_ONLY;
          endcase
        end
      end
      SCMC_SLEEP, SCMC_IDLE_LOW_ONLY, SCMC_IDLE_BOTH_CLOCKS, SCMC_IDLE_HIGH_ONLY: begin
        if (wake) begin
          st_d.mode = run_slow ? SCMC_SLOW : SCMC_FAST;
          st_d.held_sel = sysclk_select;
        end
      end
      default: begin
        st_d.mode = SCMC_FAST;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q.mode <= SCMC_FAST;
      st_q.held_sel <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign mode = st_q.mode;
  assign held_sel = st_q.held_sel;

endmodule : scmc_mode_fsm

`default_nettype wire

//--- verilog/scmc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scmc_consts.svh"

module scmc_top
  import scmc_pkg::*;
#(
  parameter int STAGES = `SCMC_DIV_STAGES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire scmc_bus_req_t bus_req,
  output logic [`SCMC_DATA_W-1:0] rdata,
  input wire logic halt,
  input wire logic wake,
  input wire logic watchdog_enable,
  input wire scmc_osc_t osc_in,
  input wire scmc_stable_t stable_in,
  output scmc_osc_ctl_t osc_ctl,
  output scmc_clk_out_t clk_out,
  output logic [STAGES:0] hs_div_taps,
  output scmc_mode_t mode_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // state of the top level, registered as one struct
  typedef struct packed {
    logic [`SCMC_SEL_W-1:0] sysclk_select;
    logic high_source_select;
    logic low_source_select;
    logic idle_high_clock_keep;
    logic idle_low_clock_keep;
    logic [1:0] rc_freq_select;
    logic rc_osc_enable;
    logic hs_crystal_range;
    logic hs_crystal_enable;
    logic ls_crystal_speedup;
    logic ls_crystal_enable;
    logic hs_src;
    logic hi_on;
    logic ls_src;
    logic lo_on;
    logic [`SCMC_SEL_W-1:0] sel_cur;
    logic sys_on;
    logic [`SCMC_DATA_W-1:0] rdata;
    scmc_osc_ctl_t osc_ctl;
    scmc_clk_out_t clk_out;
  } scmc_top_st_t;

  scmc_top_st_t st_q;
  scmc_top_st_t st_d;

  scmc_mode_t mode;
  logic [`SCMC_SEL_W-1:0] held_sel;
  logic [STAGES:0] taps;
  logic hi_gated;

  // comb helpers
  logic hs_lvl;
  logic hs_new_lvl;
  logic ls_lvl;
  logic ls_new_lvl;
  logic hs_active;
  logic hi_want;
  logic lo_want;
  logic sys_want;
  logic is_run;
  logic [`SCMC_SEL_W-1:0] sel_req;
  logic cur_lvl;
  logic req_lvl;
  logic lxt_locked;
  logic [`SCMC_DATA_W-1:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////////
  // level of the system clock source for a select code
  function automatic logic src_level(
    input logic [`SCMC_SEL_W-1:0] code,
    input logic [STAGES:0] div_taps,
    input logic low_lvl
  );
    if (code == `SCMC_SEL_LOW) begin
      src_level = low_lvl;
    end else begin
      src_level = div_taps[code];
    end
  endfunction : src_level

  ////////////////////////////////////////////////////////////////////////////////
  // mode sequencer and high clock divider
  scmc_mode_fsm u_fsm (
    .mclk(mclk),
    .rst_n(rst_n),
    .halt(halt),
    .wake(wake),
    .idle_high_clock_keep(st_q.idle_high_clock_keep),
    .idle_low_clock_keep(st_q.idle_low_clock_keep),
    .sysclk_select(st_q.sysclk_select),
    .mode(mode),
    .held_sel(held_sel)
  );

  // divided versions follow the gated high clock
  assign hi_gated = hs_lvl & st_q.hi_on;

  scmc_clk_div #(
    .STAGES(STAGES)
  ) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .high_in(hi_gated),
    .taps(taps)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register writes, oscillator control, clock selection and gating
  always_comb begin
    st_d = st_q;

    // speed-up bit frozen while the low crystal clocks the system
    lxt_locked = (st_q.sysclk_select == `SCMC_SEL_LOW) &&
                 (st_q.low_source_select == `SCMC_SRC_CRYSTAL);

    // software writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        `SCMC_OFS_SYSTEM_CLOCK_CONTROL: begin
          st_d.sysclk_select = bus_req.wdata[`SCMC_SEL_MSB:`SCMC_SEL_LSB];
          st_d.high_source_select = bus_req.wdata[`SCMC_HIGH_SRC_BIT];
          st_d.low_source_select = bus_req.wdata[`SCMC_LOW_SRC_BIT];
          st_d.idle_high_clock_keep = bus_req.wdata[`SCMC_IDLE_HIGH_BIT];
          st_d.idle_low_clock_keep = bus_req.wdata[`SCMC_IDLE_LOW_BIT];
        end
        `SCMC_OFS_HI_RC_OSC_CONTROL: begin
          st_d.rc_freq_select = bus_req.wdata[`SCMC_RC_FREQ_MSB:`SCMC_RC_FREQ_LSB];
          st_d.rc_osc_enable = bus_req.wdata[`SCMC_EN_BIT];
        end
        `SCMC_OFS_HS_CRYSTAL_CONTROL: begin
          st_d.hs_crystal_range = bus_req.wdata[`SCMC_MODE_BIT];
          st_d.hs_crystal_enable = bus_req.wdata[`SCMC_EN_BIT];
        end
        `SCMC_OFS_LS_CRYSTAL_CONTROL: begin
          if (!lxt_locked) begin
            st_d.ls_crystal_speedup = bus_req.wdata[`SCMC_MODE_BIT];
          end
          st_d.ls_crystal_enable = bus_req.wdata[`SCMC_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // read data stand for one cycle only, zero elsewhere
    rd_mux = '0;
    case (bus_req.addr)
      `SCMC_OFS_SYSTEM_CLOCK_CONTROL: begin
        rd_mux[`SCMC_SEL_MSB:`SCMC_SEL_LSB] = st_q.sysclk_select;
        rd_mux[`SCMC_HIGH_SRC_BIT] = st_q.high_source_select;
        rd_mux[`SCMC_LOW_SRC_BIT] = st_q.low_source_select;
        rd_mux[`SCMC_IDLE_HIGH_BIT] = st_q.idle_high_clock_keep;
        rd_mux[`SCMC_IDLE_LOW_BIT] = st_q.idle_low_clock_keep;
      end
      `SCMC_OFS_HI_RC_OSC_CONTROL: begin
        rd_mux[`SCMC_RC_FREQ_MSB:`SCMC_RC_FREQ_LSB] = st_q.rc_freq_select;
        rd_mux[`SCMC_FLAG_BIT] = stable_in.rc_stable_flag;
        rd_mux[`SCMC_EN_BIT] = st_q.rc_osc_enable;
      end
      `SCMC_OFS_HS_CRYSTAL_CONTROL: begin
        rd_mux[`SCMC_MODE_BIT] = st_q.hs_crystal_range;
        rd_mux[`SCMC_FLAG_BIT] = stable_in.hs_crystal_stable_flag;
        rd_mux[`SCMC_EN_BIT] = st_q.hs_crystal_enable;
      end
      `SCMC_OFS_LS_CRYSTAL_CONTROL: begin
        rd_mux[`SCMC_MODE_BIT] = st_q.ls_crystal_speedup;
        rd_mux[`SCMC_FLAG_BIT] = stable_in.ls_crystal_stable_flag;
        rd_mux[`SCMC_EN_BIT] = st_q.ls_crystal_enable;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
    st_d.rdata = bus_req.rd ? rd_mux : '0;

    // which modes need the selected high oscillator forced on
    is_run = (mode == SCMC_FAST) || (mode == SCMC_SLOW);
    hs_active = (mode == SCMC_FAST) || (mode == SCMC_IDLE_BOTH_CLOCKS) ||
                (mode == SCMC_IDLE_HIGH_ONLY);

    // high source mux, moved only while both oscillators are low
    hs_lvl = (st_q.hs_src == `SCMC_SRC_CRYSTAL) ? osc_in.hs_crystal_osc : osc_in.hs_rc_osc;
    hs_new_lvl = (st_q.high_source_select == `SCMC_SRC_CRYSTAL) ?
                 osc_in.hs_crystal_osc : osc_in.hs_rc_osc;
    if (scmc_may_switch(hs_lvl, hs_new_lvl)) begin
      st_d.hs_src = st_q.high_source_select;
    end

    // high clock on in fast and high idles; in slow per its oscillator enable
    hi_want = hs_active;
    if (mode == SCMC_SLOW) begin
      hi_want = (st_q.hs_src == `SCMC_SRC_CRYSTAL) ? st_q.hs_crystal_enable :
                st_q.rc_osc_enable;
    end
    // a tap feeding a running system clock must not freeze high
    if (!hs_lvl && (hi_want || !st_q.sys_on || (st_q.sel_cur == `SCMC_SEL_LOW))) begin
      st_d.hi_on = hi_want;
    end

    // oscillator enables: selected one forced in active modes, own bit in slow, both off in sleep and low-only idle
    st_d.osc_ctl.hs_crystal_en = 1'b0;
    st_d.osc_ctl.hs_rc_en = 1'b0;
    if (hs_active || (mode == SCMC_SLOW)) begin
      st_d.osc_ctl.hs_crystal_en = st_q.hs_crystal_enable ||
        (hs_active && (st_q.high_source_select == `SCMC_SRC_CRYSTAL));
      st_d.osc_ctl.hs_rc_en = st_q.rc_osc_enable ||
        (hs_active && (st_q.high_source_select == `SCMC_SRC_RC));
    end
    st_d.osc_ctl.rc_freq_select = st_q.rc_freq_select;
    st_d.osc_ctl.hs_crystal_range = st_q.hs_crystal_range;
    st_d.osc_ctl.ls_crystal_speedup = st_q.ls_crystal_speedup;

    // low source mux, moved only while both oscillators are low
    ls_lvl = (st_q.ls_src == `SCMC_SRC_CRYSTAL) ? osc_in.ls_crystal_osc : osc_in.ls_rc_osc;
    ls_new_lvl = (st_q.low_source_select == `SCMC_SRC_CRYSTAL) ?
                 osc_in.ls_crystal_osc : osc_in.ls_rc_osc;
    if (scmc_may_switch(ls_lvl, ls_new_lvl)) begin
      st_d.ls_src = st_q.low_source_select;
    end

    // low clock stopped in sleep and in the high-only idle
    lo_want = (mode != SCMC_SLEEP) && (mode != SCMC_IDLE_HIGH_ONLY);
    if (!ls_lvl) begin
      st_d.lo_on = lo_want;
    end
    st_d.osc_ctl.ls_crystal_en = st_q.ls_crystal_enable ||
      (lo_want && (st_q.low_source_select == `SCMC_SRC_CRYSTAL));
    st_d.osc_ctl.ls_rc_en = (mode != SCMC_SLEEP) || watchdog_enable;

    // system clock source request: live field when running, held one when idle
    sel_req = is_run ? st_q.sysclk_select : held_sel;
    cur_lvl = src_level(st_q.sel_cur, taps, st_q.clk_out.low_clock);
    req_lvl = src_level(sel_req, taps, st_q.clk_out.low_clock);
    if (scmc_may_switch(cur_lvl, req_lvl)) begin
      st_d.sel_cur = sel_req;
    end

    // system clock gating per mode
    case (mode)
      SCMC_FAST, SCMC_SLOW: sys_want = 1'b1;
      SCMC_SLEEP: sys_want = 1'b0;
      SCMC_IDLE_LOW_ONLY: sys_want = (held_sel == `SCMC_SEL_LOW);
      SCMC_IDLE_BOTH_CLOCKS: sys_want = 1'b1;
      SCMC_IDLE_HIGH_ONLY: sys_want = (held_sel != `SCMC_SEL_LOW);
      default: sys_want = 1'b0;
    endcase
    if (!cur_lvl) begin
      st_d.sys_on = sys_want;
    end

    // clock outputs
    st_d.clk_out.sysclk = cur_lvl & st_q.sys_on;
    st_d.clk_out.high_clock = hi_gated;
    st_d.clk_out.low_clock = ls_lvl & st_q.lo_on;
    st_d.clk_out.ls_rc_clock = osc_in.ls_rc_osc & st_d.osc_ctl.ls_rc_en;
    st_d.clk_out.cpu_run = is_run;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.sysclk_select <= 3'(`SCMC_RST_SYSTEM_CLOCK_CONTROL >> `SCMC_SEL_LSB);
      st_q.high_source_select <= 1'(`SCMC_RST_SYSTEM_CLOCK_CONTROL >> `SCMC_HIGH_SRC_BIT);
      st_q.low_source_select <= 1'(`SCMC_RST_SYSTEM_CLOCK_CONTROL >> `SCMC_LOW_SRC_BIT);
      st_q.rc_freq_select <= 2'(`SCMC_RST_HI_RC_OSC_CONTROL >> `SCMC_RC_FREQ_LSB);
      st_q.rc_osc_enable <= 1'(`SCMC_RST_HI_RC_OSC_CONTROL >> `SCMC_EN_BIT);
      st_q.hs_crystal_enable <= 1'(`SCMC_RST_HS_CRYSTAL_CONTROL >> `SCMC_EN_BIT);
      st_q.ls_crystal_enable <= 1'(`SCMC_RST_LS_CRYSTAL_CONTROL >> `SCMC_EN_BIT);
      st_q.hi_on <= 1'b1;
      st_q.lo_on <= 1'b1;
      st_q.sys_on <= 1'b1;
      st_q.clk_out.cpu_run <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign rdata = st_q.rdata;
  assign osc_ctl = st_q.osc_ctl;
  assign clk_out = st_q.clk_out;
  assign hs_div_taps = taps;
  assign mode_out = mode;

endmodule : scmc_top

`default_nettype wire

//--- testbench/scmc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "scmc_consts.svh"

module scmc_chk
  import scmc_pkg::*;
#(
  parameter int STAGES = `SCMC_DIV_STAGES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire scmc_bus_req_t bus_req,
  input wire logic [`SCMC_DATA_W-1:0] rdata,
  input wire logic halt,
  input wire logic wake,
  input wire logic watchdog_enable,
  input wire scmc_osc_t osc_in,
  input wire scmc_stable_t stable_in,
  input wire scmc_osc_ctl_t osc_ctl,
  input wire scmc_clk_out_t clk_out,
  input wire logic [STAGES:0] hs_div_taps,
  input wire scmc_mode_t mode_out
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic run_m;
  logic [7:0] sleep_q;
  logic [7:0] dark_q;
  // cpu-running modes
  assign run_m = (mode_out == SCMC_FAST) || (mode_out == SCMC_SLOW);

  // cycles spent in sleep
  always_ff @(posedge mclk) begin
    if (!rst_n || mode_out != SCMC_SLEEP) begin
      sleep_q <= 8'h00;
    end else if (sleep_q != 8'hFF) begin
      sleep_q <= sleep_q + 8'h01;
    end
  end

  // cycles spent in sleep with the watchdog off
  always_ff @(posedge mclk) begin
    if (!rst_n || mode_out != SCMC_SLEEP || watchdog_enable) begin
      dark_q <= 8'h00;
    end else if (dark_q != 8'hFF) begin
      dark_q <= dark_q + 8'h01;
    end
  end

  sequence run_halt_s;
    halt && run_m;
  endsequence
  sequence stop_wake_s;
    wake && !run_m;
  endsequence

  rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  mode_onehot_a: assert property ($onehot(mode_out))
    else $error("mode not one-hot");
  halt_stops_a: assert property (run_halt_s |=> !run_m)
    else $error("halt did not stop cpu");
  halt_refused_a: assert property (halt && !wake && !run_m |=> $stable(mode_out))
    else $error("halt in stop mode acted");
  wake_runs_a: assert property (stop_wake_s |=> run_m)
    else $error("wake did not resume");
  cpu_follow_a: assert property (clk_out.cpu_run == $past(run_m))
    else $error("cpu run does not follow mode");
  mode_cause_a: assert property ($changed(mode_out) && $past(rst_n) && !(run_m && $past(run_m))
    |-> $past(halt || wake))
    else $error("mode changed without halt or wake");
  freq_write_a: assert property ($changed(osc_ctl.rc_freq_select) && $past(rst_n)
    |-> $past(bus_req.wr && bus_req.addr == `SCMC_OFS_HI_RC_OSC_CONTROL, 2))
    else $error("rc frequency changed without write");
  sleep_dark_a: assert property (sleep_q >= 8'h96 |->
    !clk_out.sysclk && !clk_out.high_clock && !clk_out.low_clock)
    else $error("clock running in sleep");
  rc_dark_a: assert property (dark_q >= 8'h08 |-> !clk_out.ls_rc_clock)
    else $error("rc clock running in sleep without watchdog");
endmodule : scmc_chk

bind scmc_top scmc_chk #(.STAGES(STAGES)) u_chk (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
  .rdata(rdata), .halt(halt), .wake(wake), .watchdog_enable(watchdog_enable), .osc_in(osc_in),
  .stable_in(stable_in), .osc_ctl(osc_ctl), .clk_out(clk_out), .hs_div_taps(hs_div_taps),
  .mode_out(mode_out));
`default_nettype wire

//--- testbench/system_clock_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module system_clock_mode_control_tb;
  import scmc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic halt = 1'b0;
  logic wake = 1'b0;
  logic watchdog_enable = 1'b0;
  logic [1:0] ph = 2'h0;
  scmc_bus_req_t req = '0;
  scmc_stable_t stab = '0;
  scmc_osc_t osc;
  scmc_osc_ctl_t octl;
  scmc_clk_out_t ck;
  scmc_mode_t mode;
  logic [7:0] rdata;
  logic [6:0] taps;
  logic [10:0] watch;
  logic [7:0] v;
  int num_errors = 0;
  int compares = 0;
  logic [2:0] t_sel [6] = '{3'h0, 3'h0, 3'h7, 3'h0, 3'h0, 3'h7};
  logic [1:0] t_idle [6] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2};
  logic [2:0] t_on [6] = '{3'h0, 3'h1, 3'h5, 3'h7, 3'h6, 3'h2};
  scmc_mode_t t_mode [6] = '{SCMC_SLEEP, SCMC_IDLE_LOW_ONLY, SCMC_IDLE_LOW_ONLY,
    SCMC_IDLE_BOTH_CLOCKS, SCMC_IDLE_HIGH_ONLY, SCMC_IDLE_HIGH_ONLY};

  always #5 mclk = ~mclk;
  // crystals toggle every cycle, rc oscillators every second cycle
  always @(posedge mclk) ph <= ph + 2'h1;
  assign osc = {ph[0], ph[1], ph[0], ph[1]};
  assign watch = {taps, ck.sysclk, ck.high_clock, ck.low_clock, ck.ls_rc_clock};

  scmc_top dut (.mclk(mclk), .rst_n(rst_n), .bus_req(req), .rdata(rdata), .halt(halt),
    .wake(wake), .watchdog_enable(watchdog_enable), .osc_in(osc), .stable_in(stab),
    .osc_ctl(octl), .clk_out(ck), .hs_div_taps(taps), .mode_out(mode));

  task automatic wrap_up;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one request cycle, released at the taking edge
  task automatic drive(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r,
    input logic h, input logic k);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    halt <= h;
    wake <= k;
    @(posedge mclk);
    req <= '0;
    halt <= 1'b0;
    wake <= 1'b0;
    #1;
  endtask : drive

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    drive(a, d, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    drive(a, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
    check(what, rdata, exp);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  // rising edges of one watched clock over n cycles
  task automatic count(input int i, input int n, output int c);
    logic p;
    c = 0;
    p = watch[i];
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (watch[i] === 1'b1 && p === 1'b0) c++;
      p = watch[i];
    end
  endtask : count

  task automatic near(input string what, input int i, input int n, input int e);
    int c;
    count(i, n, c);
    check(what, 8'(c >= e - 1 && c <= e + 1), 8'h01);
  endtask : near

  task automatic on(input string what, input int i, input logic e);
    int c;
    count(i, 40, c);
    check(what, 8'(c != 0), 8'(e));
  endtask : on

  // hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    $display("run limit reached");
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    idle(1);
    rd_chk("scc", 4'h0, 8'h00);
    rd_chk("hi_rc_osc_control", 4'h1, 8'h01);
    rd_chk("hs_crystal_control", 4'h2, 8'h00);
    rd_chk("ls_crystal_control", 4'h3, 8'h00);
    wr_reg(4'h0, 8'h10);
    rd_chk("scc reserved", 4'h0, 8'h00);
    wr_reg(4'h5, 8'hFF);
    rd_chk("unmapped", 4'h5, 8'h00);
    drive(4'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    check("wake in run", mode, SCMC_FAST);
    for (int f = 0; f < 3; f++) begin
      wr_reg(4'h1, 8'(f * 4 + 1));
      idle(1);
      check("rc freq", octl.rc_freq_select, 8'(f));
      rd_chk("hi_rc_osc_control freq", 4'h1, 8'(f * 4 + 1));
    end
    @(posedge mclk) stab <= 3'h7;
    idle(2);
    rd_chk("hi_rc_osc_control flag", 4'h1, 8'h0B);
    rd_chk("hs_crystal_control flag", 4'h2, 8'h02);
    wr_reg(4'h3, 8'h05);
    idle(1);
    check("speedup on", octl.ls_crystal_speedup, 8'h01);
    wr_reg(4'h3, 8'h01);
    idle(1);
    check("speedup off", octl.ls_crystal_speedup, 8'h00);
    wr_reg(4'h0, 8'hE4);
    wr_reg(4'h3, 8'h04);
    rd_chk("ls_crystal_control frozen", 4'h3, 8'h02);
    check("speedup frozen", octl.ls_crystal_speedup, 8'h00);
    wr_reg(4'h0, 8'h08);
    wr_reg(4'h3, 8'h01);
    wr_reg(4'h2, 8'h01);
    $display("test registers done");
    idle(20);
    near("hs crystal", 2, 40, 20);
    near("ls rc", 1, 40, 10);
    wr_reg(4'h0, 8'h04);
    idle(20);
    near("hs rc", 2, 40, 10);
    near("ls crystal", 1, 40, 20);
    $display("test sources done");
    for (int n = 0; n < 8; n++) begin
      wr_reg(4'h0, 8'(n * 32 + 12));
      idle(140);
      near("sysclk rate", 3, 256, (n == 7) ? 128 : 128 >> n);
      if (n > 0 && n < 7) near("tap rate", 4 + n, 256, 128 >> n);
    end
    $display("test divider done");
    wr_reg(4'h0, 8'hE8);
    idle(140);
    check("slow mode", mode, SCMC_SLOW);
    near("slow sysclk", 3, 40, 10);
    wr_reg(4'h2, 8'h00);
    idle(10);
    check("hs enable", octl.hs_crystal_en, 8'h00);
    check("hs rc enable", octl.hs_rc_en, 8'h01);
    on("hs stopped", 2, 1'b0);
    wr_reg(4'h2, 8'h01);
    idle(10);
    on("hs kept", 2, 1'b1);
    $display("test slow done");
    for (int t = 0; t < 6; t++) begin
      v = {t_sel[t], 3'h3, t_idle[t]};
      wr_reg(4'h0, v);
      idle(140);
      drive(4'h0, v ^ 8'h03, 1'b1, 1'b0, 1'b1, 1'b0);
      check("halt mode", mode, t_mode[t]);
      idle(150);
      check("cpu stop", ck.cpu_run, 8'h00);
      on("sysclk gate", 3, t_on[t][2]);
      on("high gate", 2, t_on[t][1]);
      on("low gate", 1, t_on[t][0]);
      if (t == 0) begin
        drive(4'h0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
        check("halt refused", mode, SCMC_SLEEP);
        on("rc clock off", 0, 1'b0);
        @(posedge mclk) watchdog_enable <= 1'b1;
        idle(10);
        on("rc clock on", 0, 1'b1);
        @(posedge mclk) watchdog_enable <= 1'b0;
      end
      drive(4'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
      check("wake mode", mode, (t_sel[t] == 3'h7) ? SCMC_SLOW : SCMC_FAST);
    end
    $display("test modes done");
    @(posedge mclk) rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    idle(1);
    rd_chk("scc after reset", 4'h0, 8'h00);
    check("mode after reset", mode, SCMC_FAST);
    $display("test reset done");
    wrap_up();
  end
endmodule : system_clock_mode_control_tb
`default_nettype wire
